// [hw/cic_top.v]
// interrupt request pin and input change status registers on an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "cic_consts.vh"

// Function
// - With the tristate select at 0 the pin shows the active level when pending, the opposite otherwise.
// - With the tristate select at 1 (default) the pin is driven active when pending, released otherwise.
// - Eight change flags in bits 7 to 0 set when the validity of inputs one to eight changes.
// - All change flags read 1 after reset.
// - A flag clears when software writes 1 to it or reads the status word; writing 0 leaves it.
// - Valid-to-invalid and invalid-to-valid changes both set the flag.
module cic_top (
	input wire aclk,
	input wire aresetn,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] input_valid,
	output wire irq_req_o,
	output wire irq_req_oe,
	output wire irq_out
);

	reg awready_reg;
	reg wready_reg;
	reg [9:0] awaddr_reg;
	reg aw_held_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_held_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg arready_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	reg awready_next;
	reg wready_next;
	reg [9:0] awaddr_next;
	reg aw_held_next;
	reg [31:0] wdata_next;
	reg [3:0] wstrb_next;
	reg w_held_next;
	reg bvalid_next;
	reg [1:0] bresp_next;
	reg arready_next;
	reg rvalid_next;
	reg [31:0] rd_word_next;
	reg [1:0] rd_resp_next;

	reg [1:0] pin_cfg_reg;
	reg [1:0] pin_cfg_next;
	reg [7:0] input_change_flag_reg;
	wire [7:0] input_change_flag_next;
	reg [7:0] mask_reg;
	reg [7:0] mask_next;
	reg irq_level_reg;
	reg irq_level_next;
	reg irq_oe_reg;
	reg irq_oe_next;
	reg irq_out_reg;
	reg irq_out_next;

	wire [7:0] change_pulse;
	wire irq_polarity;
	wire tristate_inactive_select;
	wire aw_take;
	wire w_take;
	wire wr_fire;
	wire ar_take;
	wire wr_cfg;
	wire wr_sts;
	wire wr_mask;
	wire rd_sts;
	wire [7:0] clear_bits;
	wire [7:0] read_clear;
	wire pending;
	wire wr_hit;
	wire cfg_we;
	wire sts_we;
	wire mask_we;
	wire [7:0] unmasked;

	cic_edge_detect u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.valid_in(input_valid),
		.change_pulse(change_pulse)
	);

	assign irq_polarity = pin_cfg_reg[`CIC_BIT_POLARITY];
	assign tristate_inactive_select = pin_cfg_reg[`CIC_BIT_TRISTATE];

	// write path: address and data taken in either order, one at a time
	assign aw_take = s_axi_awvalid & awready_reg;
	assign w_take = s_axi_wvalid & wready_reg;
	assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign wr_hit = wr_cfg | wr_sts | wr_mask;

	always @* begin
		awready_next = awready_reg;
		wready_next = wready_reg;
		awaddr_next = awaddr_reg;
		aw_held_next = aw_held_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		w_held_next = w_held_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (aw_take) begin
			awaddr_next = s_axi_awaddr;
			aw_held_next = 1'b1;
			awready_next = 1'b0;
		end
		if (w_take) begin
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
			w_held_next = 1'b1;
			wready_next = 1'b0;
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			// unmapped offsets answer with an error and change nothing
			bresp_next = wr_hit ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 10'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CIC_RESP_OKAY;
		end else begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	assign wr_cfg = wr_fire && (awaddr_reg[9:2] == `CIC_IDX_PIN_CFG);
	assign wr_sts = wr_fire && (awaddr_reg[9:2] == `CIC_IDX_CHG_STS);
	assign wr_mask = wr_fire && (awaddr_reg[9:2] == `CIC_IDX_IRQ_MASK);

	// read path: one read at a time, answered the cycle after the address
	assign ar_take = s_axi_arvalid & arready_reg;
	assign rd_sts = ar_take && (s_axi_araddr[9:2] == `CIC_IDX_CHG_STS);

	// unmapped offsets read zero with an error response
	always @* begin
		rd_word_next = 32'h00000000;
		rd_resp_next = `CIC_RESP_OKAY;
		case (s_axi_araddr[9:2])
			`CIC_IDX_PIN_CFG: begin
				rd_word_next = {30'h00000000, pin_cfg_reg};
			end
			`CIC_IDX_CHG_STS: begin
				rd_word_next = {24'h000000, input_change_flag_reg};
			end
			`CIC_IDX_IRQ_MASK: begin
				rd_word_next = {24'h000000, mask_reg};
			end
			default: begin
				rd_resp_next = `CIC_RESP_SLVERR;
			end
		endcase
	end

	always @* begin
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		if (ar_take) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
		end
		if (rvalid_reg && s_axi_rready) begin
			arready_next = 1'b1;
			rvalid_next = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `CIC_RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word_next;
				rresp_reg <= rd_resp_next;
			end
		end
	end

	// register writes land only when the low byte lane is enabled
	assign cfg_we = wr_cfg & wstrb_reg[0];
	assign sts_we = wr_sts & wstrb_reg[0];
	assign mask_we = wr_mask & wstrb_reg[0];

	// flags clear by write of 1 or by a read of the status word
	assign clear_bits = sts_we ? wdata_reg[7:0] : 8'h00;
	assign read_clear = rd_sts ? 8'hff : 8'h00;

	// a change in the clearing cycle still sets the flag
	genvar n;
	generate
		for (n = 0; n < 8; n = n + 1) begin : g_flag
			assign input_change_flag_next[n] = (input_change_flag_reg[n] & ~clear_bits[n]
				& ~read_clear[n]) | change_pulse[n];
		end
	endgenerate

	always @* begin
		pin_cfg_next = pin_cfg_reg;
		mask_next = mask_reg;
		if (cfg_we) begin
			pin_cfg_next = wdata_reg[1:0];
		end
		if (mask_we) begin
			mask_next = wdata_reg[7:0];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_cfg_reg <= `CIC_PIN_CFG_RESET;
			input_change_flag_reg <= `CIC_CHG_STS_RESET;
			mask_reg <= `CIC_IRQ_MASK_RESET;
		end else begin
			pin_cfg_reg <= pin_cfg_next;
			input_change_flag_reg <= input_change_flag_next;
			mask_reg <= mask_next;
		end
	end

	// pin pending on any flag; the irq line honours the mask
	assign pending = |input_change_flag_reg;
	assign unmasked = input_change_flag_reg & ~mask_reg;

	always @* begin
		irq_level_next = ~irq_polarity;
		irq_oe_next = ~tristate_inactive_select;
		if (pending) begin
			irq_level_next = irq_polarity;
			irq_oe_next = 1'b1;
		end
		irq_out_next = |unmasked;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_level_reg <= 1'b1;
			irq_oe_reg <= 1'b0;
			irq_out_reg <= 1'b0;
		end else begin
			irq_level_reg <= irq_level_next;
			irq_oe_reg <= irq_oe_next;
			irq_out_reg <= irq_out_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign irq_req_o = irq_level_reg;
	assign irq_req_oe = irq_oe_reg;
	assign irq_out = irq_out_reg;

endmodule // cic_top
`default_nettype wire

// [hw/cic_consts.vh]
// register offsets, field positions and reset values of the clock input change interrupt block
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH

// printed offsets are register indices; byte address is four times the index
`define CIC_IDX_PIN_CFG 8'h0c
`define CIC_IDX_CHG_STS 8'h0d
`define CIC_IDX_IRQ_MASK 8'h10
`define CIC_ADDR_PIN_CFG 10'h030
`define CIC_ADDR_CHG_STS 10'h034
`define CIC_ADDR_IRQ_MASK 10'h040

`define CIC_BIT_POLARITY 0
`define CIC_BIT_TRISTATE 1

`define CIC_PIN_CFG_RESET 2'h2
`define CIC_CHG_STS_RESET 8'hff
`define CIC_IRQ_MASK_RESET 8'h00

`define CIC_RESP_OKAY 2'h0
`define CIC_RESP_SLVERR 2'h2

`endif

// [hw/cic_edge_detect.v]
// synchronises the per-input valid levels and flags either edge
`timescale 1ns/10ps
`default_nettype none

module cic_edge_detect (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] valid_in,
	output wire [7:0] change_pulse
);

	reg [7:0] sync1_reg;
	reg [7:0] sync2_reg;
	reg [7:0] last_reg;
	reg [2:0] fill_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			last_reg <= 8'h00;
			fill_reg <= 3'h0;
		end else begin
			sync1_reg <= valid_in;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	// either direction counts; nothing flagged before the pipe has filled
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_edge
			assign change_pulse[i] = fill_reg[2] & (sync2_reg[i] ^ last_reg[i]);
		end
	endgenerate

endmodule // cic_edge_detect
`default_nettype wire

// [verification/cic_host_irq.sv]
// host side of the interrupt request wire, pulled to its idle level
`timescale 1ns/10ps
`default_nettype none
module cic_host_irq (
	input wire logic drv,
	input wire logic oe,
	input wire logic pol,
	output wire logic seen
);
	wire logic lvl;
	assign lvl = oe ? drv : ~pol;
	assign seen = (lvl == pol);
endmodule // cic_host_irq
`default_nettype wire

// [verification/cic_top_asserts.sv]
// checker for the pin and bus handshakes of the change interrupt block
`timescale 1ns/10ps
`default_nettype none
module cic_top_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0] input_valid,
	input wire logic irq_req_oe,
	input wire logic irq_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_chg;
		$changed(input_valid) |-> ##[1:6] irq_req_oe;
	endproperty
	a_chg: assert property (p_chg) else $error("change not shown on pin");
	property p_pend;
		irq_out |-> irq_req_oe;
	endproperty
	a_pend: assert property (p_pend) else $error("pending but pin released");
	property p_bv;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_bv: assert property (p_bv) else $error("late write response");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rv;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rv: assert property (p_rv) else $error("late read data");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_wblk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wblk: assert property (p_wblk) else $error("write taken while busy");
	property p_rblk;
		s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rblk: assert property (p_rblk) else $error("read busy or upper bits set");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq_out));
endmodule // cic_top_asserts
bind cic_top cic_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .input_valid,
	.irq_req_oe, .irq_out);
`default_nettype wire

// [verification/cic_top_tb.sv]
// bench for the change interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "cic_consts.vh"
module cic_top_tb;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 1, arv = 0, rr = 1, pol = 0;
	logic [9:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, d;
	logic [7:0] iv = 0;
	logic [1:0] r;
	wire logic awrdy, wrdy, bv, arrdy, rv, io, ioe, iout, seen;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int failures = 0, num_checks = 0, i;
	initial forever #5 aclk = ~aclk;
	cic_top dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .input_valid(iv),
		.irq_req_o(io), .irq_req_oe(ioe), .irq_out(iout));
	cic_host_irq host (.drv(io), .oe(ioe), .pol(pol), .seen(seen));
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xf(input logic w, input logic [9:0] a, input logic [31:0] v);
		int k;
		logic h1, h2, h3;
		k = 0;
		if (w) begin
			awa <= a;
			wd <= v;
			awv <= 1;
			wv <= 1;
		end else begin
			ara <= a;
			arv <= 1;
		end
		do begin
			@(negedge aclk);
			h1 = w ? awrdy : arrdy;
			h2 = wrdy;
			h3 = w ? bv : rv;
			d = rdata;
			r = w ? bresp : rresp;
			@(posedge aclk);
			if (h1) begin
				awv <= 0;
				arv <= 0;
			end
			if (h2)
				wv <= 0;
			k++;
		end while (!h3 && k < 50);
		if (!h3) begin
			failures++;
			stop_test;
		end
	endtask
	task automatic pin(input logic [3:0] exp); // waits for sync, then compares pin state
		repeat (8) @(posedge aclk);
		#1 chk({ioe, io, iout, seen}, exp);
	endtask
	initial begin
		#500000;
		failures++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		pin(4'b1011);
		xf(0, `CIC_ADDR_PIN_CFG, 0);
		chk(d, 2);
		xf(1, `CIC_ADDR_CHG_STS, 'h0f);
		chk(r, 0);
		xf(0, `CIC_ADDR_CHG_STS, 0);
		chk(d, 'hf0);
		xf(0, `CIC_ADDR_CHG_STS, 0);
		chk(d, 0);
		pin(4'b0100);
		$display("reset and clear test done");
		xf(1, `CIC_ADDR_PIN_CFG, 0);
		pin(4'b1100);
		for (i = 0; i < 16; i++) begin
			iv <= iv ^ (8'h01 << i[2:0]);
			pin(4'b1011);
			xf(0, `CIC_ADDR_CHG_STS, 0);
			chk(d, 8'h01 << i[2:0]);
			pin(4'b1100);
		end
		$display("per input change test done");
		xf(1, `CIC_ADDR_PIN_CFG, 3);
		pol <= 1;
		xf(1, `CIC_ADDR_IRQ_MASK, 1);
		iv <= iv ^ 8'h01;
		pin(4'b1101);
		iv <= iv ^ 8'h02;
		pin(4'b1111);
		xf(0, `CIC_ADDR_CHG_STS, 0);
		chk(d, 3);
		pin(4'b0000);
		xf(0, 'h3c, 0);
		chk({r, d}, {2'h2, 32'h0});
		xf(1, 'h3c, 1);
		chk(r, 2);
		$display("polarity and mask test done");
		stop_test;
	end
endmodule // cic_top_tb
`default_nettype wire
